// ===== design/hbp_map.vh
// constants for the h-bridge protection and diagnostics block
// assumes a 125 mhz system clock; included by the top module, host model and bench
`ifndef HBP_MAP_VH
`define HBP_MAP_VH
// ====================================================================
// register offsets (byte addresses, 32-bit words)
`define HBP_ADDR_CTRL      8'h00
`define HBP_ADDR_STATUS    8'h04
`define HBP_ADDR_CLEAR     8'h08
// ====================================================================
// control fields
`define HBP_CTRL_CURRENT_LIMIT_SELECT_LO   0
`define HBP_CTRL_CURRENT_LIMIT_SELECT_HI   1
`define HBP_CTRL_CL_BIT    2
`define HBP_CTRL_HALF_BIT  3
`define HBP_CTRL_STANDBY_STATE_BIT  4
// ====================================================================
// status fields
`define HBP_ST_OC_BIT      0
`define HBP_ST_SC_BIT      1
`define HBP_ST_OLS_BIT     2
`define HBP_ST_OLA_BIT     3
`define HBP_ST_REG_LO      4
`define HBP_ST_REG_HI      5
// clear register: write 1 to clear
`define HBP_CLR_OC_BIT     0
`define HBP_CLR_SC_BIT     1
`define HBP_CLR_OLS_BIT    2
// ====================================================================
// reset values
`define HBP_CURRENT_LIMIT_SELECT_RESET     2'h1
`define HBP_STANDBY_STATE_RESET     1'b1
// ====================================================================
// timing
`define HBP_CLK_MHZ        125
`define HBP_BLANK_NS       32000
`define HBP_DIS_FAST_NS    8000
`define HBP_DIS_SLOW_NS    128000
`define HBP_OL_DISCH_NS    20000
`define HBP_OL_FILT_NS     20000
`define HBP_NS_CYC(ns)     (((ns) * `HBP_CLK_MHZ + 999) / 1000)
`endif

// ===== design/hbp_top.v
// top of the h-bridge protection and diagnostics logic
// assumes comparator and pin inputs asynchronous; wishbone on sys_clk
// ====================================================================
// Summary of operation
// - four limit thresholds picked by two bits
// - over-limit starts regulation and sets flag
// - blanking interval of 32 us from exceedance
// - then high-side recirculation for twice decay
// - after recirculation release gates to inputs
// - warning halves threshold, same regulation timing
// - warning level latched only between blanking intervals
// - no switch-on while current above limit
// - switch-off command acts at once, resets regulation
// - warning masks short detect blank plus recirc
// - standby check needs standby, hi-z, full bridge
// - check starts on wake or enable rising
// - stage one both low sides on, shorts active
// - stage two pull-up on a, filter, record open
// - after latching result restore commanded outputs
// - switching open load without overshoot in window
// - active open-load result held until next window
// - active flag clears on load seen or leave
// - filtered short turns driver off, sets flag
// - driver stays off until host clears short
// - recovery within 8 us with check disabled
// - recovery within 128 us with check enabled
// - half-bridge disables limit and open-load logic
// - limit code reset value is 01
`timescale 1ns/10ps
`include "hbp_map.vh"
module hbp_top #(
    parameter BLANK_CYC  = `HBP_NS_CYC(`HBP_BLANK_NS),
    parameter SLOW_CYC   = (`HBP_DIS_SLOW_NS * `HBP_CLK_MHZ) / 1000,
    parameter FAST_CYC   = (`HBP_DIS_FAST_NS * `HBP_CLK_MHZ) / 1000,
    parameter DISCH_CYC  = `HBP_NS_CYC(`HBP_OL_DISCH_NS),
    parameter FILT_CYC   = `HBP_NS_CYC(`HBP_OL_FILT_NS),
    parameter CNT_W      = 16
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // host pins
    input  wire        in_a,
    input  wire        in_b,
    input  wire        output_disable_pin,
    // power stage comparators
    input  wire        cmp_over_limit,
    input  wire        cmp_short,
    input  wire        temp_warning_level,
    input  wire        cmp_open_a,
    input  wire        cmp_overshoot,
    // gate drives and threshold
    output reg         gate_hs_a,
    output reg         gate_ls_a,
    output reg         gate_hs_b,
    output reg         gate_ls_b,
    output reg         pullup_a,
    output reg  [1:0]  current_limit_threshold,
    output reg         limit_half
);
    // ================================================================
    // state codes
    localparam RG_IDLE  = 3'b001;
    localparam RG_BLANK = 3'b010;
    localparam RG_RECIR = 3'b100;
    localparam OL_IDLE  = 3'b001;
    localparam OL_DISCH = 3'b010;
    localparam OL_FILT  = 3'b100;
    // ================================================================
    // input synchronisers
    reg  [9:0] sync1;
    reg  [9:0] sync2;
    always @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= 10'h000;
            sync2 <= 10'h000;
        end else begin
            sync1 <= {in_a, in_b, output_disable_pin, cmp_over_limit,
                      cmp_short, temp_warning_level, cmp_open_a,
                      cmp_overshoot, 2'b00};
            sync2 <= sync1;
        end
    end
    wire s_in_a  = sync2[9];
    wire s_in_b  = sync2[8];
    wire s_dis   = sync2[7];
    wire s_ovl   = sync2[6];
    wire s_sc    = sync2[5];
    wire s_tw    = sync2[4];
    wire s_open  = sync2[3];
    wire s_ovs   = sync2[2];
    // ================================================================
    // registers
    reg  [1:0] current_limit_select;
    reg        load_check_enable;
    reg        half_mode;
    reg        standby_state;
    reg        overcurrent_flag;
    reg        short_flag;
    reg        open_standby_state_flag;
    reg        open_act_flag;
    reg  [2:0] rg_state;
    reg  [2:0] ol_state;
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
    wire       wr_ctrl = wb_wr && (wb_adr_i == `HBP_ADDR_CTRL);
    wire       wr_clr  = wb_wr && (wb_adr_i == `HBP_ADDR_CLEAR);
    wire       clr_oc  = wr_clr & wb_dat_i[`HBP_CLR_OC_BIT];
    wire       clr_sc  = wr_clr & wb_dat_i[`HBP_CLR_SC_BIT];
    wire       clr_ols = wr_clr & wb_dat_i[`HBP_CLR_OLS_BIT];
    reg  [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        if (wb_adr_i == `HBP_ADDR_CTRL) begin
            rd_data[4:0] = {standby_state, half_mode, load_check_enable,
                            current_limit_select};
        end else if (wb_adr_i == `HBP_ADDR_STATUS) begin
            rd_data[5:0] = {(rg_state == RG_RECIR), (rg_state == RG_BLANK),
                            open_act_flag, open_standby_state_flag, short_flag,
                            overcurrent_flag};
        end
    end
    always @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o             <= 1'b0;
            wb_dat_o             <= 32'h00000000;
            current_limit_select <= `HBP_CURRENT_LIMIT_SELECT_RESET;
            load_check_enable    <= 1'b0;
            half_mode            <= 1'b0;
            standby_state        <= `HBP_STANDBY_STATE_RESET;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h00000000;
            if (wr_ctrl) begin
                current_limit_select <= wb_dat_i[`HBP_CTRL_CURRENT_LIMIT_SELECT_HI:
                                                 `HBP_CTRL_CURRENT_LIMIT_SELECT_LO];
                load_check_enable <= wb_dat_i[`HBP_CTRL_CL_BIT];
                half_mode         <= wb_dat_i[`HBP_CTRL_HALF_BIT];
                standby_state     <= wb_dat_i[`HBP_CTRL_STANDBY_STATE_BIT];
            end
        end
    end
    // ================================================================
    // check start events
    reg        cl_q;
    reg        standby_state_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            cl_q   <= 1'b0;
            standby_state_q <= `HBP_STANDBY_STATE_RESET;
        end else begin
            cl_q   <= load_check_enable;
            standby_state_q <= standby_state;
        end
    end
    wire wake  = standby_state_q & ~standby_state;
    wire cl_up = standby_state & load_check_enable & ~cl_q;
    wire ol_go = ~half_mode & ((wake & load_check_enable) | cl_up);
    // ================================================================
    // current limit regulation
    reg  [CNT_W-1:0] rg_cnt;
    reg  [CNT_W-1:0] decay_cnt;
    reg              decayed;
    reg              warn_lat;
    wire             bridge_on = ~standby_state & ~short_flag & ~s_dis;
    reg              in_a_q;
    reg              in_b_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            in_a_q <= 1'b0;
            in_b_q <= 1'b0;
        end else begin
            in_a_q <= s_in_a;
            in_b_q <= s_in_b;
        end
    end
    wire cmd_off  = (in_a_q & ~s_in_a) | (in_b_q & ~s_in_b);
    wire lim_able = ~half_mode & bridge_on;
    always @(posedge sys_clk) begin
        if (rst) begin
            rg_state  <= RG_IDLE;
            rg_cnt    <= {CNT_W{1'b0}};
            decay_cnt <= {CNT_W{1'b0}};
            decayed   <= 1'b0;
            warn_lat  <= 1'b0;
        end else if (cmd_off | ~lim_able) begin
            rg_state <= RG_IDLE;
            rg_cnt   <= {CNT_W{1'b0}};
            warn_lat <= s_tw;
        end else begin
            case (rg_state)
                RG_IDLE: begin
                    warn_lat <= s_tw;
                    if (s_ovl) begin
                        rg_state <= RG_BLANK;
                        rg_cnt   <= {CNT_W{1'b0}};
                    end
                end
                RG_BLANK: begin
                    rg_cnt <= rg_cnt + 1'b1;
                    if (rg_cnt == BLANK_CYC[CNT_W-1:0] - 1'b1) begin
                        rg_state  <= RG_RECIR;
                        rg_cnt    <= {CNT_W{1'b0}};
                        decay_cnt <= {CNT_W{1'b0}};
                        decayed   <= 1'b0;
                    end
                end
                RG_RECIR: begin
                    rg_cnt <= rg_cnt + 1'b1;
                    if (!decayed) begin
                        if (s_ovl) begin
                            decay_cnt <= decay_cnt + 1'b1;
                        end else begin
                            decayed <= 1'b1;
                        end
                    end
                    if (decayed && rg_cnt >= {decay_cnt[CNT_W-2:0], 1'b0})
                    begin
                        rg_state <= RG_IDLE;
                    end
                end
                default: rg_state <= RG_IDLE;
            endcase
        end
    end
    wire in_reg    = (rg_state != RG_IDLE);
    wire sc_masked = warn_lat & in_reg;
    // ================================================================
    // short detection with filter
    reg  [CNT_W-1:0] sc_cnt;
    wire             sc_hit = (sc_cnt == FAST_CYC[CNT_W-1:0]);
    always @(posedge sys_clk) begin
        if (rst) begin
            sc_cnt <= {CNT_W{1'b0}};
        end else if (s_sc & ~sc_masked & ~sc_hit) begin
            sc_cnt <= sc_cnt + 1'b1;
        end else if (~s_sc | sc_masked) begin
            sc_cnt <= {CNT_W{1'b0}};
        end
    end
    // ================================================================
    // standby open-load sequence
    reg  [CNT_W-1:0] ol_cnt;
    wire ol_ok = ~half_mode & ~short_flag;
    always @(posedge sys_clk) begin
        if (rst) begin
            ol_state <= OL_IDLE;
            ol_cnt   <= {CNT_W{1'b0}};
        end else begin
            case (ol_state)
                OL_IDLE: begin
                    ol_cnt <= {CNT_W{1'b0}};
                    if (ol_go) begin
                        ol_state <= OL_DISCH;
                    end
                end
                OL_DISCH: begin
                    ol_cnt <= ol_cnt + 1'b1;
                    if (short_flag | half_mode) begin
                        ol_state <= OL_IDLE;
                    end else if (ol_cnt == DISCH_CYC[CNT_W-1:0]) begin
                        ol_state <= OL_FILT;
                        ol_cnt   <= {CNT_W{1'b0}};
                    end
                end
                OL_FILT: begin
                    ol_cnt <= ol_cnt + 1'b1;
                    if (short_flag | half_mode |
                        ol_cnt == FILT_CYC[CNT_W-1:0]) begin
                        ol_state <= OL_IDLE;
                    end
                end
                default: ol_state <= OL_IDLE;
            endcase
        end
    end
    wire ol_result = (ol_state == OL_FILT) &&
                     (ol_cnt == FILT_CYC[CNT_W-1:0]) && s_open;
    wire ol_busy   = (ol_state != OL_IDLE);
    // ================================================================
    // active open-load window
    reg  win_open;
    reg  win_seen;
    wire switching = ~half_mode & ~standby_state & (s_in_a ^ s_in_b);
    always @(posedge sys_clk) begin
        if (rst) begin
            win_open      <= 1'b0;
            win_seen      <= 1'b0;
            open_act_flag <= 1'b0;
        end else if (standby_state | half_mode) begin
            win_open      <= 1'b0;
            win_seen      <= 1'b0;
            open_act_flag <= 1'b0;
        end else if (!win_open && cmd_off) begin
            win_open <= 1'b1;
            win_seen <= 1'b0;
        end else if (win_open) begin
            if (s_ovs) begin
                win_seen <= 1'b1;
            end
            if (switching) begin
                win_open      <= 1'b0;
                open_act_flag <= ~(win_seen | s_ovs);
            end
        end
    end
    // ================================================================
    // sticky flags, set wins over clear
    always @(posedge sys_clk) begin
        if (rst) begin
            overcurrent_flag <= 1'b0;
            short_flag       <= 1'b0;
            open_standby_state_flag   <= 1'b0;
        end else begin
            overcurrent_flag <= (lim_able & s_ovl & ~in_reg) |
                                (overcurrent_flag & ~clr_oc);
            short_flag       <= sc_hit |
                                (short_flag & ~clr_sc);
            open_standby_state_flag   <= ol_result |
                                (open_standby_state_flag & ~clr_ols);
        end
    end
    // ================================================================
    // disable recovery delay
    reg  [CNT_W-1:0] rec_cnt;
    reg              recovered;
    wire [CNT_W-1:0] rec_lim = load_check_enable ? SLOW_CYC[CNT_W-1:0]
                                                 : FAST_CYC[CNT_W-1:0];
    always @(posedge sys_clk) begin
        if (rst) begin
            rec_cnt   <= {CNT_W{1'b0}};
            recovered <= 1'b0;
        end else if (s_dis | standby_state) begin
            rec_cnt   <= {CNT_W{1'b0}};
            recovered <= 1'b0;
        end else if (!recovered) begin
            rec_cnt <= rec_cnt + 1'b1;
            if ((rec_cnt >= rec_lim - 1'b1) && !ol_busy) begin
                recovered <= 1'b1;
            end
        end
    end
    // ================================================================
    // gate drive outputs
    wire run   = bridge_on & recovered & ~short_flag;
    wire blk_a = lim_able & s_ovl & ~gate_hs_a;
    wire blk_b = lim_able & s_ovl & ~gate_hs_b;
    wire on_a  = s_in_a & ~blk_a;
    wire on_b  = s_in_b & ~blk_b;
    wire recir = (rg_state == RG_RECIR) & ~cmd_off;
    always @(posedge sys_clk) begin
        if (rst) begin
            gate_hs_a               <= 1'b0;
            gate_ls_a               <= 1'b0;
            gate_hs_b               <= 1'b0;
            gate_ls_b               <= 1'b0;
            pullup_a                <= 1'b0;
            current_limit_threshold <= `HBP_CURRENT_LIMIT_SELECT_RESET;
            limit_half              <= 1'b0;
        end else begin
            current_limit_threshold <= current_limit_select;
            limit_half              <= warn_lat;
            pullup_a                <= (ol_state == OL_FILT) & ol_ok;
            if (ol_busy & ol_ok) begin
                gate_hs_a <= 1'b0;
                gate_hs_b <= 1'b0;
                gate_ls_a <= (ol_state == OL_DISCH);
                gate_ls_b <= 1'b1;
            end else if (!run) begin
                gate_hs_a <= 1'b0;
                gate_ls_a <= 1'b0;
                gate_hs_b <= 1'b0;
                gate_ls_b <= 1'b0;
            end else if (recir) begin
                gate_hs_a <= 1'b1;
                gate_ls_a <= 1'b0;
                gate_hs_b <= 1'b1;
                gate_ls_b <= 1'b0;
            end else begin
                gate_hs_a <= on_a;
                gate_ls_a <= ~on_a;
                gate_hs_b <= on_b;
                gate_ls_b <= ~on_b;
            end
        end
    end
endmodule

// ===== verification/hbp_properties.sv
// checker for the h-bridge protection block, bound onto hbp_top
// assumes one clock sys_clk and synchronous active high rst
`timescale 1ns/10ps
module hbp_properties #(
    parameter FAST_CYC = 10
) (
    // clock and reset
    input wire       sys_clk,
    input wire       rst,
    // bus and pins
    input wire       wb_ack_o,
    input wire       in_a,
    input wire       output_disable_pin,
    // comparators
    input wire       cmp_short,
    input wire       temp_warning_level,
    // gate drives and threshold
    input wire       gate_hs_a,
    input wire       gate_ls_a,
    input wire       gate_hs_b,
    input wire       gate_ls_b,
    input wire       pullup_a,
    input wire [1:0] current_limit_threshold,
    input wire       limit_half
);
    // ================================================================
    // helper: run of unmasked short cycles
    logic [7:0] sc_run;
    wire        gates_on = gate_hs_a | gate_ls_a | gate_hs_b | gate_ls_b;
    always @(posedge sys_clk)
        if (rst || !cmp_short || temp_warning_level)
            sc_run <= 8'h00;
        else if (sc_run != 8'hff)
            sc_run <= sc_run + 8'h01;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ================================================================
    // properties
    AST_CODE_BY_WRITE: assert property (
        $changed(current_limit_threshold) |-> $past(wb_ack_o))
        else $error("code change without write");
    AST_RECIRC_HS: assert property (
        gate_hs_a && gate_hs_b |-> !gate_ls_a && !gate_ls_b)
        else $error("low side on in recirc");
    AST_HALF_CAUSE: assert property (
        $rose(limit_half) |-> $past(temp_warning_level, 4))
        else $error("halved without warning");
    AST_OFF_FAST: assert property (
        $fell(in_a) |-> ##3 !gate_hs_a)
        else $error("high side a still on");
    AST_PULLUP_STAGE: assert property (
        pullup_a |-> gate_ls_b && !gate_ls_a && !gate_hs_a && !gate_hs_b)
        else $error("pull-up with wrong gates");
    AST_SHORT_OFF: assert property (
        sc_run >= FAST_CYC + 4 |-> !gates_on)
        else $error("gates on after filtered short");
    AST_DIS_OFF: assert property (
        output_disable_pin [*4] |-> !gates_on)
        else $error("gates on while disabled");
    AST_CODE_RESET: assert property (
        $fell(rst) |-> current_limit_threshold == 2'h1)
        else $error("bad code after reset");
    cover property ($rose(gate_hs_a && gate_hs_b));
    cover property ($rose(pullup_a));
    cover property ($rose(limit_half));
endmodule
bind hbp_top hbp_properties #(.FAST_CYC(FAST_CYC)) u_props (
    .sys_clk(sys_clk), .rst(rst), .wb_ack_o(wb_ack_o), .in_a(in_a),
    .output_disable_pin(output_disable_pin), .cmp_short(cmp_short),
    .temp_warning_level(temp_warning_level), .gate_hs_a(gate_hs_a),
    .gate_ls_a(gate_ls_a), .gate_hs_b(gate_hs_b), .gate_ls_b(gate_ls_b),
    .pullup_a(pullup_a), .limit_half(limit_half),
    .current_limit_threshold(current_limit_threshold)
);

// ===== verification/hbp_host_model.sv
// host model: wishbone master and bridge input pins
// assumes the bench watchdog ends a bus wait that hangs
`timescale 1ns/10ps
`include "hbp_map.vh"
module hbp_host_model (
    // clock
    input  wire         sys_clk,
    // wishbone master
    output logic        wb_cyc_i,
    output logic        wb_stb_i,
    output logic        wb_we_i,
    output logic [7:0]  wb_adr_i,
    output logic [3:0]  wb_sel_i,
    output logic [31:0] wb_dat_i,
    input  wire         wb_ack_o,
    input  wire  [31:0] wb_dat_o,
    // bridge pins
    output logic        in_a,
    output logic        in_b,
    output logic        output_disable_pin
);
    // ================================================================
    // bus and pin tasks
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, in_a, in_b} = 5'h00;
        output_disable_pin = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
    end
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= {3'($urandom), 1'b1};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_dat_i <= ~d;
    endtask
    task pins(input logic a, input logic b, input logic d);
        @(posedge sys_clk);
        in_a <= a;
        in_b <= b;
        output_disable_pin <= d;
    endtask
    task clear_faults(input logic [31:0] m);
        logic [31:0] q;
        bus(1'b1, `HBP_ADDR_CLEAR, m, q);
    endtask
endmodule

// ===== verification/tb_hbridge_protection_diagnostics.sv
// self-checking bench for the protection block
// assumes hbp_host_model; the bench drives the comparators
`timescale 1ns/10ps
`include "hbp_map.vh"
module tb_hbridge_protection_diagnostics;
    localparam BLANK = 40;
    localparam SLOW  = 160;
    localparam FAST  = 10;
    logic        sys_clk, rst, cmp_over_limit, cmp_short;
    logic        temp_warning_level, cmp_open_a, cmp_overshoot;
    wire         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    wire  [7:0]  wb_adr_i;
    wire  [3:0]  wb_sel_i;
    wire  [31:0] wb_dat_i, wb_dat_o;
    wire         in_a, in_b, output_disable_pin, limit_half;
    wire         gate_hs_a, gate_ls_a, gate_hs_b, gate_ls_b, pullup_a;
    wire  [1:0]  current_limit_threshold;
    wire  [4:0]  gv = {gate_hs_a, gate_ls_a, gate_hs_b, gate_ls_b, pullup_a};
    logic [31:0] expq[$];
    logic [31:0] rd_q;
    integer      n_mismatch = 0, comparisons = 0, n, i;
    // ================================================================
    // design, host and clock
    hbp_top #(.BLANK_CYC(BLANK), .SLOW_CYC(SLOW), .FAST_CYC(FAST),
              .DISCH_CYC(20), .FILT_CYC(20)) DUT (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .in_a(in_a), .in_b(in_b),
        .output_disable_pin(output_disable_pin),
        .cmp_over_limit(cmp_over_limit), .cmp_short(cmp_short),
        .temp_warning_level(temp_warning_level), .cmp_open_a(cmp_open_a),
        .cmp_overshoot(cmp_overshoot), .gate_hs_a(gate_hs_a),
        .gate_ls_a(gate_ls_a), .gate_hs_b(gate_hs_b), .gate_ls_b(gate_ls_b),
        .pullup_a(pullup_a), .limit_half(limit_half),
        .current_limit_threshold(current_limit_threshold));
    hbp_host_model host (
        .sys_clk(sys_clk), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .in_a(in_a), .in_b(in_b), .output_disable_pin(output_disable_pin));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ================================================================
    // tasks and read monitor
    task fail(input string m);
        n_mismatch++;
        $display("MISMATCH t=%0t %0s", $time, m);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp) fail(m);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        host.bus(1'b0, a, 32'h0, rd_q);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.bus(1'b1, a, d, rd_q);
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge sys_clk);
    endtask
    task wait_gv(input logic [4:0] e, input integer lim, input string m);
        n = 0;
        while (gv !== e && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        chk({3'h0, gv}, {3'h0, e}, m);
    endtask
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            comparisons++;
            if (expq.size() == 0) fail("unexpected read");
            else if (wb_dat_o !== expq.pop_front()) fail("read data");
        end
    initial begin
        #(8 * 20000);
        fail("watchdog expired");
        tally_and_finish;
    end
    // ================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {cmp_over_limit, cmp_short, temp_warning_level} = 3'h0;
        {cmp_open_a, cmp_overshoot} = 2'h0;
        i = $urandom(64);
        cyc(8);
        rst <= 1'b0;
        rd(`HBP_ADDR_CTRL, 32'h11);
        rd(`HBP_ADDR_STATUS, 32'h0);
        rd(8'h0c, 32'h0);
        chk({3'h0, gv}, 8'h00, "standby gates");
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            n = (i < 4) ? i : $urandom % 4;
            wr(`HBP_ADDR_CTRL, 32'h10 | n);
            cyc(2);
            chk({6'h0, current_limit_threshold}, n[7:0], "code");
            rd(`HBP_ADDR_CTRL, 32'h10 | n);
        end
        $display("test limit codes done");
        host.pins(1'b1, 1'b0, 1'b0);
        cmp_open_a <= 1'b1;
        wr(`HBP_ADDR_CTRL, 32'h05);
        wait_gv(5'b01010, 40, "discharge stage");
        wait_gv(5'b00011, 40, "pull-up stage");
        wait_gv(5'b10010, 400, "restore");
        rd(`HBP_ADDR_STATUS, 32'h04);
        cmp_open_a <= 1'b0;
        host.clear_faults(32'h04);
        rd(`HBP_ADDR_STATUS, 32'h00);
        $display("test standby check done");
        @(posedge sys_clk);
        cmp_over_limit <= 1'b1;
        wait_gv(5'b10100, BLANK + 20, "recirculation");
        chk({7'h0, n >= BLANK}, 8'h01, "blanking short");
        cyc(10);
        cmp_over_limit <= 1'b0;
        wait_gv(5'b10010, 60, "release");
        chk({7'h0, n >= 10 && n <= 22}, 8'h01, "recirc length");
        rd(`HBP_ADDR_STATUS, 32'h01);
        host.clear_faults(32'h01);
        $display("test regulation done");
        @(posedge sys_clk);
        cmp_over_limit <= 1'b1;
        host.pins(1'b0, 1'b0, 1'b0);
        wait_gv(5'b01010, 8, "switch-off");
        host.pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        chk({7'h0, gate_hs_a}, 8'h00, "switch-on");
        cmp_over_limit <= 1'b0;
        wait_gv(5'b10010, 200, "on after limit");
        rd(`HBP_ADDR_STATUS, 32'h19);
        cmp_overshoot <= 1'b1;
        host.pins(1'b0, 1'b0, 1'b0);
        host.pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        rd(`HBP_ADDR_STATUS, 32'h01);
        host.clear_faults(32'h01);
        $display("test input override done");
        temp_warning_level <= 1'b1;
        cyc(6);
        chk({7'h0, limit_half}, 8'h01, "half limit");
        temp_warning_level <= 1'b0;
        cyc(6);
        chk({7'h0, limit_half}, 8'h00, "full limit");
        @(posedge sys_clk);
        cmp_short <= 1'b1;
        wait_gv(5'b00000, FAST + 8, "short shutdown");
        cmp_short <= 1'b0;
        cyc(30);
        chk({3'h0, gv}, 8'h00, "held off");
        rd(`HBP_ADDR_STATUS, 32'h02);
        host.clear_faults(32'h02);
        wait_gv(5'b10010, 400, "restored");
        $display("test warning and short done");
        for (i = 0; i < 2; i++) begin
            wr(`HBP_ADDR_CTRL, i ? 32'h09 : 32'h05);
            host.pins(1'b1, 1'b0, 1'b1);
            wait_gv(5'b00000, 8, "disable");
            host.pins(1'b1, 1'b0, 1'b0);
            wait_gv(5'b10010, i ? FAST + 8 : SLOW + 8, "recovery");
        end
        cmp_over_limit <= 1'b1;
        cyc(4);
        rd(`HBP_ADDR_STATUS, 32'h00);
        $display("test disable recovery done");
        tally_and_finish;
    end
endmodule
